// >>> logic/cprb_config_port.sv
`timescale 1ns/1ns
`include "cprb_params.svh"
`default_nettype none

module cprb_config_port
  import cprb_pkg::*;
#(
  parameter int POR_BLOCK_CYCLES = `CPRB_POR_BLOCK_CYCLES,
  parameter logic [7:0] DEVICE_IDENTIFIER = 8'h5a, // arbitrary value
  parameter logic [7:0] DEVICE_REV = 8'h01 // arbitrary value
)
(
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins
  input wire logic host_bus_reset_n,
  input wire logic strap_sel,
  // decoded host i/o cycles
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  output logic io_ack,
  // status
  output logic config_mode,
  output logic host_ready,
  // floppy bank settings
  output logic floppy_bank_active,
  output logic [15:0] floppy_bank_base,
  output logic [7:0] floppy_bank_irq,
  output logic [7:0] floppy_bank_dma,
  output logic [7:0] floppy_bank_mode,
  // printer bank settings
  output logic printer_active,
  output logic [15:0] printer_base,
  output logic [7:0] printer_irq,
  output logic [7:0] printer_dma,
  output logic [7:0] printer_mode
);

  cprb_state_type s_r;
  cprb_state_type s_nxt;

  function automatic logic [7:0] strap_port(input logic strap);
    strap_port = strap ? `CPRB_PORT_STRAP_HI : `CPRB_PORT_STRAP_LO;
  endfunction

  function automatic logic is_test(input logic [7:0] idx);
    is_test = (idx >= `CPRB_IDX_TEST_FIRST) && (idx <= `CPRB_IDX_TEST_LAST);
  endfunction

  function automatic logic [7:0] read_reg(input cprb_state_type s, input logic [7:0] idx);
    read_reg = 8'h00;
    if (idx <= `CPRB_IDX_GLOBAL_LAST)
    begin
      unique case (idx)
        `CPRB_IDX_BANK_SELECT: read_reg = s.bank;
        `CPRB_IDX_DEVICE_IDENTIFIER: read_reg = DEVICE_IDENTIFIER;
        `CPRB_IDX_DEVICE_REV: read_reg = DEVICE_REV;
        `CPRB_IDX_POWER_CONTROL: read_reg = s.power_control;
        `CPRB_IDX_POWER_MGMT: read_reg = s.power_management;
        `CPRB_IDX_OSC_CONTROL: read_reg = s.oscillator_control;
        `CPRB_IDX_PORT_ADDR_LOW: read_reg = s.port_low;
        `CPRB_IDX_PORT_ADDR_HIGH: read_reg = s.port_high;
        8'h2a: read_reg = s.test_f;
        8'h2b: read_reg = s.test_d;
        8'h2c: read_reg = s.test_e;
        8'h2d: read_reg = s.test_a;
        8'h2e: read_reg = s.test_b;
        8'h2f: read_reg = s.test_c;
        // control is write-only, reserved read zero
        default: read_reg = 8'h00;
      endcase
    end
    else if (s.bank == `CPRB_BANK_FLOPPY)
    begin
      unique case (idx)
        `CPRB_IDX_ACTIVATE: read_reg = s.fd_activate;
        `CPRB_IDX_BASE_HIGH: read_reg = s.fd_base_high;
        `CPRB_IDX_BASE_LOW: read_reg = s.fd_base_low;
        `CPRB_IDX_IRQ_SELECT: read_reg = s.fd_irq;
        `CPRB_IDX_DMA_SELECT: read_reg = s.fd_dma;
        `CPRB_IDX_MODE: read_reg = s.fd_mode;
        `CPRB_IDX_OPTION: read_reg = s.fd_option;
        `CPRB_IDX_TYPE: read_reg = s.fd_type;
        `CPRB_IDX_DRIVE0: read_reg = s.fd_drive0;
        `CPRB_IDX_DRIVE1: read_reg = s.fd_drive1;
        default: read_reg = 8'h00;
      endcase
    end
    else if (s.bank == `CPRB_BANK_PRINTER)
    begin
      unique case (idx)
        `CPRB_IDX_ACTIVATE: read_reg = s.pp_activate;
        `CPRB_IDX_BASE_HIGH: read_reg = s.pp_base_high;
        `CPRB_IDX_BASE_LOW: read_reg = s.pp_base_low;
        `CPRB_IDX_IRQ_SELECT: read_reg = s.pp_irq;
        `CPRB_IDX_DMA_SELECT: read_reg = s.pp_dma;
        `CPRB_IDX_MODE: read_reg = s.pp_mode;
        default: read_reg = 8'h00;
      endcase
    end
  endfunction

  // values loaded by any reset that defines a soft value
  function automatic cprb_state_type soft_reset(input cprb_state_type s);
    soft_reset = s;
    soft_reset.bank = `CPRB_RST_ZERO;
    soft_reset.power_control = `CPRB_RST_ZERO;
    soft_reset.fd_activate = `CPRB_RST_ZERO;
    soft_reset.fd_base_high = `CPRB_RST_FLOPPY_BASE_HIGH;
    soft_reset.fd_base_low = `CPRB_RST_FLOPPY_BASE_LOW;
    soft_reset.fd_irq = `CPRB_RST_FLOPPY_IRQ;
    soft_reset.fd_dma = `CPRB_RST_FLOPPY_DMA;
    soft_reset.pp_activate = `CPRB_RST_ZERO;
    soft_reset.pp_base_high = `CPRB_RST_ZERO;
    soft_reset.pp_base_low = `CPRB_RST_ZERO;
    soft_reset.pp_irq = `CPRB_RST_ZERO;
    soft_reset.pp_dma = `CPRB_RST_PRINTER_DMA;
  endfunction

  // hard reset: soft values plus the rest, tests kept
  function automatic cprb_state_type hard_reset(input cprb_state_type s);
    hard_reset = soft_reset(s);
    hard_reset.mode = CPRB_RUN;
    hard_reset.index = 8'h00;
    hard_reset.power_management = `CPRB_RST_ZERO;
    hard_reset.oscillator_control = `CPRB_RST_OSC;
    hard_reset.port_high = `CPRB_PORT_ADDR_HIGH_RST;
    hard_reset.fd_mode = `CPRB_RST_FLOPPY_MODE;
    hard_reset.fd_option = `CPRB_RST_ZERO;
    hard_reset.fd_type = `CPRB_RST_FLOPPY_TYPE;
    hard_reset.fd_drive0 = `CPRB_RST_ZERO;
    hard_reset.fd_drive1 = `CPRB_RST_ZERO;
    hard_reset.pp_mode = `CPRB_RST_PRINTER_MODE;
  endfunction

  // full power-on image; port low byte follows the strap when the block ends
  function automatic cprb_state_type power_on_state();
    power_on_state = '0;
    power_on_state.rst_sync = 2'b11;
    power_on_state.strap_sync = 2'b00;
    power_on_state.rst_seen = 1'b0;
    power_on_state.por_cnt = 16'h0000;
    power_on_state.por_done = 1'b0;
    power_on_state.mode = CPRB_RUN;
    power_on_state.index = 8'h00;
    power_on_state.bank = `CPRB_RST_ZERO;
    power_on_state.power_control = `CPRB_RST_ZERO;
    power_on_state.power_management = `CPRB_RST_ZERO;
    power_on_state.oscillator_control = `CPRB_RST_OSC;
    power_on_state.port_low = `CPRB_PORT_STRAP_LO;
    power_on_state.port_high = `CPRB_PORT_ADDR_HIGH_RST;
    power_on_state.test_f = `CPRB_RST_ZERO;
    power_on_state.test_d = `CPRB_RST_ZERO;
    power_on_state.test_e = `CPRB_RST_ZERO;
    power_on_state.test_a = `CPRB_RST_ZERO;
    power_on_state.test_b = `CPRB_RST_ZERO;
    power_on_state.test_c = `CPRB_RST_ZERO;
    power_on_state.fd_activate = `CPRB_RST_ZERO;
    power_on_state.fd_base_high = `CPRB_RST_FLOPPY_BASE_HIGH;
    power_on_state.fd_base_low = `CPRB_RST_FLOPPY_BASE_LOW;
    power_on_state.fd_irq = `CPRB_RST_FLOPPY_IRQ;
    power_on_state.fd_dma = `CPRB_RST_FLOPPY_DMA;
    power_on_state.fd_mode = `CPRB_RST_FLOPPY_MODE;
    power_on_state.fd_option = `CPRB_RST_ZERO;
    power_on_state.fd_type = `CPRB_RST_FLOPPY_TYPE;
    power_on_state.fd_drive0 = `CPRB_RST_ZERO;
    power_on_state.fd_drive1 = `CPRB_RST_ZERO;
    power_on_state.pp_activate = `CPRB_RST_ZERO;
    power_on_state.pp_base_high = `CPRB_RST_ZERO;
    power_on_state.pp_base_low = `CPRB_RST_ZERO;
    power_on_state.pp_irq = `CPRB_RST_ZERO;
    power_on_state.pp_dma = `CPRB_RST_PRINTER_DMA;
    power_on_state.pp_mode = `CPRB_RST_PRINTER_MODE;
    power_on_state.rdata = 8'h00;
    power_on_state.ack = 1'b0;
  endfunction

  logic [15:0] port_addr;
  logic [15:0] data_addr;
  logic hard_active;
  logic por_open;
  logic hit_index;
  logic hit_data;
  logic wr_index;
  logic wr_data;
  logic rd_index;
  logic rd_data;

  // host cycle decode, settled before the state update reads it
  always_comb
  begin
    port_addr = {s_r.port_high, s_r.port_low};
    data_addr = port_addr + 16'h0001;
    hard_active = !s_r.rst_sync[1];
    por_open = s_r.por_done && !hard_active;
    hit_index = por_open && (io_addr == port_addr);
    hit_data = por_open && (s_r.mode == CPRB_CONFIG) && (io_addr == data_addr);
    wr_index = io_wr && hit_index;
    wr_data = io_wr && hit_data;
    rd_index = io_rd && hit_index && (s_r.mode == CPRB_CONFIG);
    rd_data = io_rd && hit_data;
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rst_sync = {s_r.rst_sync[0], host_bus_reset_n};
    s_nxt.strap_sync = {s_r.strap_sync[0], strap_sel};
    s_nxt.rst_seen = s_r.rst_sync[1];
    s_nxt.ack = 1'b0;
    // power-on block, strap taken when it ends
    if (!s_r.por_done)
    begin
      if (s_r.por_cnt >= 16'(POR_BLOCK_CYCLES - 1))
      begin
        s_nxt.por_done = 1'b1;
        s_nxt.port_low = strap_port(s_r.strap_sync[1]);
      end
      else
      begin
        s_nxt.por_cnt = s_r.por_cnt + 16'h0001;
      end
    end
    if (hard_active)
    begin
      s_nxt = hard_reset(s_nxt);
      if (s_r.rst_seen)
      begin
        s_nxt.port_low = strap_port(s_r.strap_sync[1]);
      end
    end
    else if (wr_index)
    begin
      if (s_r.mode == CPRB_RUN)
      begin
        if (io_wdata == `CPRB_KEY_ENTER)
        begin
          s_nxt.mode = CPRB_CONFIG;
        end
      end
      else if (io_wdata == `CPRB_KEY_EXIT)
      begin
        s_nxt.mode = CPRB_RUN;
        s_nxt.ack = 1'b1;
      end
      else
      begin
        s_nxt.index = io_wdata;
        s_nxt.ack = 1'b1;
      end
    end
    else if (wr_data)
    begin
      s_nxt.ack = 1'b1;
      if (s_r.index <= `CPRB_IDX_GLOBAL_LAST)
      begin
        unique case (s_r.index)
          `CPRB_IDX_CONFIG_CONTROL:
          begin
            if (io_wdata[`CPRB_SOFT_RESET_BIT])
            begin
              s_nxt = soft_reset(s_nxt);
            end
          end
          `CPRB_IDX_BANK_SELECT: s_nxt.bank = io_wdata;
          `CPRB_IDX_POWER_CONTROL: s_nxt.power_control = io_wdata;
          `CPRB_IDX_POWER_MGMT: s_nxt.power_management = io_wdata;
          `CPRB_IDX_OSC_CONTROL: s_nxt.oscillator_control = io_wdata;
          `CPRB_IDX_PORT_ADDR_LOW: s_nxt.port_low = io_wdata;
          `CPRB_IDX_PORT_ADDR_HIGH: s_nxt.port_high = io_wdata;
          8'h2a: s_nxt.test_f = io_wdata;
          8'h2b: s_nxt.test_d = io_wdata;
          8'h2c: s_nxt.test_e = io_wdata;
          8'h2d: s_nxt.test_a = io_wdata;
          8'h2e: s_nxt.test_b = io_wdata;
          8'h2f: s_nxt.test_c = io_wdata;
          // id, revision and reserved ignore writes
          default: s_nxt.ack = 1'b1;
        endcase
      end
      else if (s_r.bank == `CPRB_BANK_FLOPPY)
      begin
        unique case (s_r.index)
          `CPRB_IDX_ACTIVATE: s_nxt.fd_activate = io_wdata;
          `CPRB_IDX_BASE_HIGH: s_nxt.fd_base_high = io_wdata;
          `CPRB_IDX_BASE_LOW: s_nxt.fd_base_low = io_wdata;
          `CPRB_IDX_IRQ_SELECT: s_nxt.fd_irq = io_wdata;
          `CPRB_IDX_DMA_SELECT: s_nxt.fd_dma = io_wdata;
          `CPRB_IDX_MODE: s_nxt.fd_mode = io_wdata;
          `CPRB_IDX_OPTION: s_nxt.fd_option = io_wdata;
          `CPRB_IDX_TYPE: s_nxt.fd_type = io_wdata;
          `CPRB_IDX_DRIVE0: s_nxt.fd_drive0 = io_wdata;
          `CPRB_IDX_DRIVE1: s_nxt.fd_drive1 = io_wdata;
          default: s_nxt.ack = 1'b1;
        endcase
      end
      else if (s_r.bank == `CPRB_BANK_PRINTER)
      begin
        unique case (s_r.index)
          `CPRB_IDX_ACTIVATE: s_nxt.pp_activate = io_wdata;
          `CPRB_IDX_BASE_HIGH: s_nxt.pp_base_high = io_wdata;
          `CPRB_IDX_BASE_LOW: s_nxt.pp_base_low = io_wdata;
          `CPRB_IDX_IRQ_SELECT: s_nxt.pp_irq = io_wdata;
          `CPRB_IDX_DMA_SELECT: s_nxt.pp_dma = io_wdata;
          `CPRB_IDX_MODE: s_nxt.pp_mode = io_wdata;
          default: s_nxt.ack = 1'b1;
        endcase
      end
    end
    else if (rd_index)
    begin
      s_nxt.rdata = s_r.index;
      s_nxt.ack = 1'b1;
    end
    else if (rd_data)
    begin
      s_nxt.rdata = read_reg(s_r, s_r.index);
      s_nxt.ack = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_r <= power_on_state();
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign io_rdata = s_r.rdata;
  assign io_ack = s_r.ack;
  assign config_mode = (s_r.mode == CPRB_CONFIG);
  assign host_ready = s_r.por_done;
  assign floppy_bank_active = s_r.fd_activate[0];
  assign floppy_bank_base = {s_r.fd_base_high, s_r.fd_base_low};
  assign floppy_bank_irq = s_r.fd_irq;
  assign floppy_bank_dma = s_r.fd_dma;
  assign floppy_bank_mode = s_r.fd_mode;
  assign printer_active = s_r.pp_activate[0];
  assign printer_base = {s_r.pp_base_high, s_r.pp_base_low};
  assign printer_irq = s_r.pp_irq;
  assign printer_dma = s_r.pp_dma;
  assign printer_mode = s_r.pp_mode;

endmodule

`default_nettype wire

// >>> logic/cprb_params.svh
`ifndef CPRB_PARAMS_SVH
`define CPRB_PARAMS_SVH

// timing
`define CPRB_MCLK_PERIOD_NS 100
`define CPRB_POR_BLOCK_NS 500000
`define CPRB_POR_BLOCK_CYCLES ((`CPRB_POR_BLOCK_NS + `CPRB_MCLK_PERIOD_NS - 1) / `CPRB_MCLK_PERIOD_NS)

// keys and port addresses
`define CPRB_KEY_ENTER 8'h55
`define CPRB_KEY_EXIT 8'haa
`define CPRB_PORT_STRAP_LO 8'h2e
`define CPRB_PORT_STRAP_HI 8'h4e
`define CPRB_PORT_ADDR_HIGH_RST 8'h00

// global indices
`define CPRB_IDX_CONFIG_CONTROL 8'h02
`define CPRB_IDX_RESERVED_A 8'h03
`define CPRB_IDX_BANK_SELECT 8'h07
`define CPRB_IDX_DEVICE_IDENTIFIER 8'h20
`define CPRB_IDX_DEVICE_REV 8'h21
`define CPRB_IDX_POWER_CONTROL 8'h22
`define CPRB_IDX_POWER_MGMT 8'h23
`define CPRB_IDX_OSC_CONTROL 8'h24
`define CPRB_IDX_PORT_ADDR_LOW 8'h26
`define CPRB_IDX_PORT_ADDR_HIGH 8'h27
`define CPRB_IDX_RESERVED_B 8'h28
`define CPRB_IDX_TEST_FIRST 8'h2a
`define CPRB_IDX_TEST_LAST 8'h2f
`define CPRB_IDX_GLOBAL_LAST 8'h2f
`define CPRB_SOFT_RESET_BIT 0

// banked indices
`define CPRB_IDX_ACTIVATE 8'h30
`define CPRB_IDX_BASE_HIGH 8'h60
`define CPRB_IDX_BASE_LOW 8'h61
`define CPRB_IDX_IRQ_SELECT 8'h70
`define CPRB_IDX_DMA_SELECT 8'h74
`define CPRB_IDX_MODE 8'hf0
`define CPRB_IDX_OPTION 8'hf1
`define CPRB_IDX_TYPE 8'hf2
`define CPRB_IDX_DRIVE0 8'hf4
`define CPRB_IDX_DRIVE1 8'hf5

// bank numbers
`define CPRB_BANK_FLOPPY 8'h00
`define CPRB_BANK_PRINTER 8'h03

// reset values
`define CPRB_RST_ZERO 8'h00
`define CPRB_RST_OSC 8'h04
`define CPRB_RST_FLOPPY_BASE_HIGH 8'h03
`define CPRB_RST_FLOPPY_BASE_LOW 8'hf0
`define CPRB_RST_FLOPPY_IRQ 8'h06
`define CPRB_RST_FLOPPY_DMA 8'h02
`define CPRB_RST_FLOPPY_MODE 8'h0e
`define CPRB_RST_FLOPPY_TYPE 8'hff
`define CPRB_RST_PRINTER_DMA 8'h04
`define CPRB_RST_PRINTER_MODE 8'h3c

`endif

// >>> logic/cprb_pkg.sv
package cprb_pkg;

  typedef enum logic {CPRB_RUN, CPRB_CONFIG} cprb_mode_type;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] strap_sync;
    logic rst_seen;
    logic [15:0] por_cnt;
    logic por_done;
    cprb_mode_type mode;
    logic [7:0] index;
    logic [7:0] bank;
    logic [7:0] power_control;
    logic [7:0] power_management;
    logic [7:0] oscillator_control;
    logic [7:0] port_low;
    logic [7:0] port_high;
    logic [7:0] test_f;
    logic [7:0] test_d;
    logic [7:0] test_e;
    logic [7:0] test_a;
    logic [7:0] test_b;
    logic [7:0] test_c;
    logic [7:0] fd_activate;
    logic [7:0] fd_base_high;
    logic [7:0] fd_base_low;
    logic [7:0] fd_irq;
    logic [7:0] fd_dma;
    logic [7:0] fd_mode;
    logic [7:0] fd_option;
    logic [7:0] fd_type;
    logic [7:0] fd_drive0;
    logic [7:0] fd_drive1;
    logic [7:0] pp_activate;
    logic [7:0] pp_base_high;
    logic [7:0] pp_base_low;
    logic [7:0] pp_irq;
    logic [7:0] pp_dma;
    logic [7:0] pp_mode;
    logic [7:0] rdata;
    logic ack;
  } cprb_state_type;

endpackage

// >>> testbench/cprb_config_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
module cprb_config_port_properties #(
  parameter int POR_BLOCK_CYCLES = 20
)
(
  // clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_bus_reset_n,
  // host cycles
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_ack,
  // status and settings
  input wire logic config_mode,
  input wire logic host_ready,
  input wire logic floppy_bank_active,
  input wire logic [15:0] floppy_bank_base
);
  int blk_cnt_r;

  // edges spent in the power-on block
  always_ff @(posedge mclk)
    if (!rst_n)
      blk_cnt_r <= 0;
    else if (!host_ready)
      blk_cnt_r <= blk_cnt_r + 1;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_enter_key: assert property (
    $rose(config_mode) |-> $past(io_wr) && $past(io_wdata) == 8'h55)
    else $error("config state entered without entry key");
  a_exit_key: assert property (
    $fell(config_mode) && $past(host_bus_reset_n, 1) && $past(host_bus_reset_n, 2)
    && $past(host_bus_reset_n, 3) |-> $past(io_wr) && $past(io_wdata) == 8'haa)
    else $error("config state left without exit key");
  a_run_silent: assert property (io_ack |-> $past(config_mode))
    else $error("access answered in run state");
  a_ack_cause: assert property (io_ack |-> $past(io_wr) || $past(io_rd))
    else $error("answer without a request");
  a_por_gate: assert property (io_ack |-> $past(host_ready))
    else $error("access answered during power-on block");
  a_ready_holds: assert property (host_ready |=> host_ready)
    else $error("ready dropped after block");
  a_block_len: assert property (
    blk_cnt_r <= POR_BLOCK_CYCLES + 1
    && (!$rose(host_ready) || blk_cnt_r >= POR_BLOCK_CYCLES - 1))
    else $error("power-on block length wrong");
  a_por_values: assert property (
    !host_ready |-> !config_mode && !floppy_bank_active && floppy_bank_base == 16'h03f0)
    else $error("wrong state during power-on block");
  a_hard_values: assert property (
    !$past(host_bus_reset_n, 3) && !$past(host_bus_reset_n, 4)
    |-> !config_mode && !floppy_bank_active && floppy_bank_base == 16'h03f0)
    else $error("wrong state under hard reset");

  c_enter: cover property ($rose(config_mode));
  c_exit: cover property ($fell(config_mode));
  c_read: cover property (io_ack && $past(io_rd));
endmodule

bind cprb_config_port cprb_config_port_properties #(.POR_BLOCK_CYCLES(POR_BLOCK_CYCLES)) chk_u (
  .mclk(mclk),
  .rst_n(rst_n),
  .host_bus_reset_n(host_bus_reset_n),
  .io_wdata(io_wdata),
  .io_wr(io_wr),
  .io_rd(io_rd),
  .io_ack(io_ack),
  .config_mode(config_mode),
  .host_ready(host_ready),
  .floppy_bank_active(floppy_bank_active),
  .floppy_bank_base(floppy_bank_base)
);
`default_nettype wire

// >>> testbench/cprb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cprb_host_model
(
  // clock
  input wire logic mclk,
  // host cycle lines
  output var logic [15:0] io_addr,
  output var logic [7:0] io_wdata,
  output var logic io_wr,
  output var logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_ack
);
  initial
  begin
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end

  // one strobe cycle, answer taken one cycle on; released lines show garbage
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic ack, output logic [7:0] q);
    @(negedge mclk);
    io_wr = w;
    io_rd = !w;
    io_addr = a;
    io_wdata = d;
    @(negedge mclk);
    ack = io_ack;
    q = io_rdata;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_config_port_register_bank.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module test_config_port_register_bank;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  localparam logic [7:0] REV = 8'h07; // arbitrary value
  localparam logic [7:0] GI [11] = '{8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h2a, 8'h2b,
    8'h2c, 8'h2d, 8'h2e, 8'h2f};
  localparam logic [7:0] GE [11] = '{8'h00, 8'h00, 8'h04, 8'h2e, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] FI [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hf0, 8'hf1,
    8'hf2, 8'hf4};
  localparam logic [7:0] FE [9] = '{8'h00, 8'h03, 8'hf0, 8'h06, 8'h02, 8'h0e, 8'h00,
    8'hff, 8'h00};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hbr_n = 1'b1;
  logic strap_sel = 1'b0;
  logic [15:0] io_addr;
  logic [15:0] fd_base;
  logic [15:0] port = 16'h002e;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [7:0] pr_irq;
  logic [15:0] pr_base;
  logic [7:0] fd_irq;
  logic [7:0] fd_dma;
  logic [7:0] fd_mode;
  logic [7:0] pr_dma;
  logic [7:0] pr_mode;
  logic pr_act;
  logic [7:0] q;
  logic io_wr;
  logic io_rd;
  logic io_ack;
  logic config_mode;
  logic host_ready;
  logic fd_act;
  logic ack;
  int n_fail = 0;
  int n_compared = 0;

  always #50 mclk = ~mclk;

  cprb_config_port #(.POR_BLOCK_CYCLES(20), .DEVICE_IDENTIFIER(ID), .DEVICE_REV(REV)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .host_bus_reset_n(hbr_n), .strap_sel(strap_sel),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .io_ack(io_ack), .config_mode(config_mode),
    .host_ready(host_ready), .floppy_bank_active(fd_act), .floppy_bank_base(fd_base),
    .floppy_bank_irq(fd_irq), .floppy_bank_dma(fd_dma), .floppy_bank_mode(fd_mode),
    .printer_active(pr_act), .printer_base(pr_base), .printer_irq(pr_irq),
    .printer_dma(pr_dma), .printer_mode(pr_mode)
  );

  cprb_host_model host_u (
    .mclk(mclk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata(io_rdata), .io_ack(io_ack)
  );

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, ack, q);
  endtask

  task automatic set_reg(input logic [7:0] idx, input logic [7:0] d);
    put(port, idx);
    put(port + 16'h0001, d);
  endtask

  task automatic get_reg(input logic [7:0] idx, input logic [7:0] ex, input string nm);
    put(port, idx);
    host_u.xfer(1'b0, port + 16'h0001, 8'h00, ack, q);
    `CHK({nm, " ack"}, 1'b1, ack)
    `CHK(nm, ex, q)
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    put(port, 8'h55);
    `CHK("blocked key", 1'b0, config_mode)
    `CHK("fd_base", 16'h03f0, fd_base)
    `CHK("fd_act", 1'b0, fd_act)
    `CHK("fd irq rst", 8'h06, fd_irq)
    `CHK("fd dma rst", 8'h02, fd_dma)
    `CHK("fd mode rst", 8'h0e, fd_mode)
    `CHK("pp act rst", 1'b0, pr_act)
    `CHK("pp base rst", 16'h0000, pr_base)
    `CHK("pp dma rst", 8'h04, pr_dma)
    `CHK("pp mode rst", 8'h3c, pr_mode)
    for (int i = 0; i < 40 && host_ready !== 1'b1; i++) @(negedge mclk);
    `CHK("host_ready", 1'b1, host_ready)
    $display("test power_on done");
    put(port, 8'h12);
    `CHK("wrong key", 1'b0, config_mode)
    host_u.xfer(1'b0, port + 16'h0001, 8'h00, ack, q);
    `CHK("run data ack", 1'b0, ack)
    put(port, 8'h55);
    `CHK("key ack", 1'b0, ack)
    `CHK("enter", 1'b1, config_mode)
    put(port, 8'h55);
    `CHK("index ack", 1'b1, ack)
    `CHK("key again", 1'b1, config_mode)
    $display("test keys done");
    for (int i = 0; i < 11; i++) get_reg(GI[i], GE[i], "global");
    get_reg(8'h21, REV, "rev");
    set_reg(8'h20, 8'hff);
    get_reg(8'h20, ID, "id");
    set_reg(8'h03, 8'hff);
    get_reg(8'h03, 8'h00, "reserved");
    for (int i = 0; i < 9; i++) get_reg(FI[i], FE[i], "floppy");
    set_reg(8'h07, 8'h03);
    get_reg(8'h07, 8'h03, "bank");
    host_u.xfer(1'b0, port, 8'h00, ack, q);
    `CHK("index read", 8'h07, q)
    get_reg(8'h20, ID, "id in bank");
    get_reg(8'h74, 8'h04, "pp dma");
    get_reg(8'hf0, 8'h3c, "pp mode");
    set_reg(8'h70, 8'h07);
    `CHK("pp irq", 8'h07, pr_irq)
    set_reg(8'h30, 8'h01);
    set_reg(8'h61, 8'h78);
    set_reg(8'h74, 8'h01);
    set_reg(8'hf0, 8'h11);
    `CHK("pp act out", 1'b1, pr_act)
    `CHK("pp base out", 16'h0078, pr_base)
    `CHK("pp dma out", 8'h01, pr_dma)
    `CHK("pp mode out", 8'h11, pr_mode)
    $display("test registers done");
    set_reg(8'h07, 8'h00);
    set_reg(8'hf2, 8'h5a);
    set_reg(8'h23, 8'h11);
    set_reg(8'h30, 8'h01);
    set_reg(8'h60, 8'h12);
    set_reg(8'h70, 8'h05);
    set_reg(8'h74, 8'h03);
    set_reg(8'hf0, 8'h0a);
    `CHK("fd irq out", 8'h05, fd_irq)
    `CHK("fd dma out", 8'h03, fd_dma)
    `CHK("fd mode out", 8'h0a, fd_mode)
    `CHK("fd_act", 1'b1, fd_act)
    `CHK("fd_base", 16'h12f0, fd_base)
    set_reg(8'h07, 8'h03);
    set_reg(8'h02, 8'h01);
    `CHK("soft fd_base", 16'h03f0, fd_base)
    `CHK("soft fd_act", 1'b0, fd_act)
    `CHK("soft pp irq", 8'h00, pr_irq)
    `CHK("soft fd irq", 8'h06, fd_irq)
    `CHK("soft fd dma", 8'h02, fd_dma)
    `CHK("soft fd mode", 8'h0a, fd_mode)
    `CHK("soft pp act", 1'b0, pr_act)
    `CHK("soft pp base", 16'h0000, pr_base)
    `CHK("soft pp dma", 8'h04, pr_dma)
    `CHK("soft pp mode", 8'h11, pr_mode)
    get_reg(8'h07, 8'h00, "soft bank");
    get_reg(8'hf2, 8'h5a, "soft fd type");
    get_reg(8'h23, 8'h11, "soft power");
    $display("test soft_reset done");
    set_reg(8'h26, 8'h3e);
    port = 16'h003e;
    get_reg(8'h20, ID, "moved id");
    host_u.xfer(1'b0, 16'h002f, 8'h00, ack, q);
    `CHK("old port ack", 1'b0, ack)
    set_reg(8'h30, 8'h01);
    $display("test relocate done");
    strap_sel = 1'b1;
    hbr_n = 1'b0;
    repeat (5) @(negedge mclk);
    hbr_n = 1'b1;
    repeat (4) @(negedge mclk);
    `CHK("hard mode", 1'b0, config_mode)
    `CHK("hard fd_act", 1'b0, fd_act)
    `CHK("hard fd mode", 8'h0e, fd_mode)
    `CHK("hard pp mode", 8'h3c, pr_mode)
    port = 16'h004e;
    put(port, 8'h55);
    `CHK("strap port", 1'b1, config_mode)
    get_reg(8'h26, 8'h4e, "strap low");
    get_reg(8'h23, 8'h00, "hard power");
    put(port, 8'haa);
    `CHK("exit ack", 1'b1, ack)
    `CHK("exit", 1'b0, config_mode)
    $display("test hard_reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
